// >>> ucm_ctrl.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ucm_ctrl #(
  parameter int TO_WIDTH = 16                  // timeout counter width
) (
  input  wire logic        pclk,               // clock, 50 MHz
  input  wire logic        presetn,            // async reset, active low
  input  wire logic        psel,               // apb select
  input  wire logic        penable,            // apb enable
  input  wire logic        pwrite,             // apb direction
  input  wire logic [7:0]  paddr,              // apb byte address
  input  wire logic [31:0] pwdata,             // apb write data
  output logic      [31:0] prdata,             // apb read data
  output logic             pready,             // apb ready
  output logic             pslverr,            // apb error
  input  wire logic        bit_tick,           // one bit period enable
  input  wire logic        rxd_pin,            // serial input pin
  output logic             txd_pin,            // serial output pin
  input  wire logic        tx_serial,          // transmitter serial output
  output logic             rx_serial,          // receiver serial input
  input  wire logic        tx_busy,            // holding or shift reg not empty
  input  wire logic        rx_char_done,       // character received pulse
  input  wire logic [8:0]  rx_char,            // received character
  input  wire logic        ev_parity,          // parity error pulse
  input  wire logic        ev_frame,           // framing error pulse
  input  wire logic        ev_overrun,         // overrun pulse
  input  wire logic        ev_manchester_error_flag,          // manchester error pulse
  input  wire logic        ev_underrun,        // underrun pulse
  input  wire logic        ev_break,           // break received pulse
  input  wire logic        ev_iter,            // iteration pulse
  input  wire logic        ev_nack,            // nack pulse
  output logic             rx_reset,           // receiver reset pulse
  output logic             tx_reset,           // transmitter reset pulse
  output logic             rx_active,          // receiver enabled
  output logic             tx_active,          // transmitter enabled
  output logic             addr_mark,          // next tx char is address
  output logic             tx_hold_wr,         // tx holding write pulse
  output logic [8:0]       tx_hold_data,       // tx holding data
  output logic             term_ready_n,       // terminal ready pin level
  output logic             req_send_n          // request-to-send / select level
);
  // reload constant needs two bits; the value field holds 32
  if (TO_WIDTH < 2 || TO_WIDTH > 32) begin : g_to_width_bad
    $error("TO_WIDTH out of range");
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire [31:0] mode_q;
  logic [31:0] mode_r_q, baud_q, rxto_q, txtg_q, ratio_q, irfilt_q, manch_q;
  logic [31:0] irq_mask_q, rxhold_q, state_q;
  logic        wp_en_q, wp_viol_q;
  logic [3:0]  wp_src_q;

  function automatic logic [3:0] prot_src(input logic [7:0] a);
    unique case (a)
      ucm_pkg::OFS_MODE:   prot_src = ucm_pkg::SRC_MODE;
      ucm_pkg::OFS_BAUD:   prot_src = ucm_pkg::SRC_BAUD;
      ucm_pkg::OFS_RXTO:   prot_src = ucm_pkg::SRC_RXTO;
      ucm_pkg::OFS_TXTG:   prot_src = ucm_pkg::SRC_TXTG;
      ucm_pkg::OFS_RATIO:  prot_src = ucm_pkg::SRC_RATIO;
      ucm_pkg::OFS_IRFILT: prot_src = ucm_pkg::SRC_IRFILT;
      ucm_pkg::OFS_MANCH:  prot_src = ucm_pkg::SRC_MANCH;
      default:             prot_src = 4'h0;
    endcase
  endfunction

  wire [3:0] wr_src   = prot_src(paddr);
  wire       wr_prot  = wr_en && (wr_src != 4'h0);
  wire       violate  = wr_prot && wp_en_q;
  wire       cfg_wr   = wr_prot && !wp_en_q;
  wire       cmd_wr   = wr_en && (paddr == ucm_pkg::OFS_CMD);
  wire       key_ok   = pwdata[31:ucm_pkg::WP_KEY_LSB] == ucm_pkg::WP_KEY;
  wire       wpm_wr   = wr_en && (paddr == ucm_pkg::OFS_WP_MODE) && key_ok;
  wire [31:0] cmd     = cmd_wr ? pwdata : 32'h0000_0000;

  assign mode_q  = mode_r_q;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r_q <= ucm_pkg::RST_ZERO;
      baud_q   <= ucm_pkg::RST_ZERO;
      rxto_q   <= ucm_pkg::RST_ZERO;
      txtg_q   <= ucm_pkg::RST_ZERO;
      ratio_q  <= ucm_pkg::RST_RATIO;
      irfilt_q <= ucm_pkg::RST_ZERO;
      manch_q  <= ucm_pkg::RST_MANCH;
    end else if (cfg_wr) begin
      unique case (wr_src)
        ucm_pkg::SRC_MODE:   mode_r_q <= pwdata;
        ucm_pkg::SRC_BAUD:   baud_q   <= pwdata;
        ucm_pkg::SRC_RXTO:   rxto_q   <= pwdata;
        ucm_pkg::SRC_TXTG:   txtg_q   <= pwdata;
        ucm_pkg::SRC_RATIO:  ratio_q  <= pwdata;
        ucm_pkg::SRC_IRFILT: irfilt_q <= pwdata;
        default:             manch_q  <= pwdata;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // write protection
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_en_q   <= 1'b0;
      wp_viol_q <= 1'b0;
      wp_src_q  <= 4'h0;
    end else begin
      if (wpm_wr) wp_en_q <= pwdata[0];
      // violation wins over a simultaneous clear
      if (violate) begin
        wp_viol_q <= 1'b1;
        wp_src_q  <= wr_src;
      end else if (wpm_wr) begin
        wp_viol_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // modes and pin routing
  // ---------------------------------------------------------------
  wire [3:0] op_mode = mode_q[ucm_pkg::MODE_OP_LSB +: 4];
  wire spi_master = op_mode == ucm_pkg::OP_SPI_MASTER;
  wire spi_mode   = spi_master || (op_mode == ucm_pkg::OP_SPI_SLAVE);
  wire iso_mode   = (op_mode == ucm_pkg::OP_ISO_T0) || (op_mode == ucm_pkg::OP_ISO_T1);
  wire multidrop  = mode_q[ucm_pkg::MODE_PAR_LSB +: 3] == ucm_pkg::PAR_MULTIDROP;
  ucm_pkg::ucm_chan_t chan;
  assign chan = ucm_pkg::ucm_chan_t'(mode_q[ucm_pkg::MODE_CH_LSB +: 2]);

  logic rx_on_q, tx_on_q;
  logic brk_line;
  always_comb begin
    rx_serial = rxd_pin;
    txd_pin   = tx_serial & ~brk_line;
    unique case (chan)
      ucm_pkg::CH_NORMAL: ;
      ucm_pkg::CH_ECHO:   txd_pin = rxd_pin;
      ucm_pkg::CH_LOCAL: begin
        rx_serial = tx_serial & ~brk_line;
        txd_pin   = 1'b1;
      end
      ucm_pkg::CH_REMOTE: begin
        txd_pin   = rxd_pin;
        rx_serial = 1'b1;
      end
    endcase
  end
  // both ends disabled in remote loopback
  assign rx_active = rx_on_q && (chan != ucm_pkg::CH_REMOTE);
  assign tx_active = tx_on_q && (chan != ucm_pkg::CH_REMOTE);

  // ---------------------------------------------------------------
  // command bits
  // ---------------------------------------------------------------
  // self-clearing resets
  assign rx_reset = cmd[ucm_pkg::CMD_RX_RST];
  assign tx_reset = cmd[ucm_pkg::CMD_TX_RST];
  assign tx_hold_wr   = wr_en && (paddr == ucm_pkg::OFS_TXHOLD);
  assign tx_hold_data = pwdata[8:0];

  logic trdy_q, rts_q, addr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_on_q <= 1'b0;
      tx_on_q <= 1'b0;
      trdy_q  <= 1'b1;
      rts_q   <= 1'b1;
      addr_q  <= 1'b0;
    end else begin
      if (cmd[ucm_pkg::CMD_RX_OFF]) rx_on_q <= 1'b0;
      else if (cmd[ucm_pkg::CMD_RX_ON]) rx_on_q <= 1'b1;
      if (cmd[ucm_pkg::CMD_TX_OFF]) tx_on_q <= 1'b0;
      else if (cmd[ucm_pkg::CMD_TX_ON]) tx_on_q <= 1'b1;
      if (cmd[ucm_pkg::CMD_TRDY_LO]) trdy_q <= 1'b0;
      else if (cmd[ucm_pkg::CMD_TRDY_HI]) trdy_q <= 1'b1;
      if (cmd[ucm_pkg::CMD_RTS_LO]) rts_q <= 1'b0;
      else if (cmd[ucm_pkg::CMD_RTS_HI]) rts_q <= 1'b1;
      if (cmd[ucm_pkg::CMD_ADDR] && multidrop) addr_q <= 1'b1;
      else if (tx_hold_wr) addr_q <= 1'b0;
    end
  end
  assign term_ready_n = trdy_q;
  assign req_send_n   = rts_q;
  assign addr_mark    = addr_q;

  // ---------------------------------------------------------------
  // status flags; events win over clears, except to_flag, where the timeout arm command wins over expiry
  // ---------------------------------------------------------------
  logic to_flag;
  wire  sta_clr  = cmd[ucm_pkg::CMD_STA_CLR];
  // iteration clear gated by smart-card mode
  wire  iter_clr = cmd[ucm_pkg::CMD_ITER_CLR] && iso_mode;
  wire  nack_clr = cmd[ucm_pkg::CMD_NACK_CLR];
  logic f_par, f_frm, f_ovr, f_man, f_und, f_brk, f_itr, f_nak, f_rxrdy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {f_par, f_frm, f_ovr, f_man, f_und, f_brk} <= 6'h00;
      {f_itr, f_nak, f_rxrdy} <= 3'h0;
      rxhold_q <= ucm_pkg::RST_ZERO;
    end else begin
      f_par <= ev_parity   | (f_par & ~sta_clr);
      f_frm <= ev_frame    | (f_frm & ~sta_clr);
      f_ovr <= ev_overrun  | (f_ovr & ~sta_clr);
      f_man <= ev_manchester_error_flag   | (f_man & ~sta_clr);
      f_und <= ev_underrun | (f_und & ~sta_clr);
      f_brk <= ev_break    | (f_brk & ~sta_clr);
      f_itr <= ev_iter     | (f_itr & ~iter_clr);
      f_nak <= ev_nack     | (f_nak & ~nack_clr);
      if (rx_char_done) begin
        rxhold_q <= {23'h000000, rx_char};
        f_rxrdy  <= 1'b1;
      end else if (rd_en && paddr == ucm_pkg::OFS_RXHOLD) begin
        f_rxrdy  <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // receiver timeout
  // ---------------------------------------------------------------
  logic [TO_WIDTH-1:0] to_cnt_q;
  logic                to_wait_q, to_run_q;
  wire [TO_WIDTH-1:0]  to_val = rxto_q[TO_WIDTH-1:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_cnt_q  <= '0;
      to_wait_q <= 1'b1;
      to_run_q  <= 1'b0;
      to_flag   <= 1'b0;
    end else if (cmd[ucm_pkg::CMD_TO_ARM]) begin
      to_wait_q <= 1'b1;
      to_run_q  <= 1'b0;
      to_flag   <= 1'b0;
      to_cnt_q  <= to_val;
    end else if (cmd[ucm_pkg::CMD_TO_RST]) begin
      to_wait_q <= 1'b0;
      to_run_q  <= 1'b1;
      to_cnt_q  <= to_val;
    end else if (rx_char_done) begin
      to_wait_q <= 1'b0;
      to_run_q  <= 1'b1;
      to_cnt_q  <= to_val;
    end else if (to_run_q && !to_wait_q && bit_tick && to_val != '0) begin
      if (to_cnt_q <= {{(TO_WIDTH-1){1'b0}}, 1'b1}) begin
        to_run_q <= 1'b0;
        if (!spi_mode) to_flag <= 1'b1;
      end else begin
        to_cnt_q <= to_cnt_q - 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // break sequencer
  // ---------------------------------------------------------------
  ucm_pkg::ucm_brk_t brk_q;
  logic [4:0]        brk_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_q     <= ucm_pkg::BRK_IDLE;
      brk_cnt_q <= 5'h00;
    end else begin
      unique case (brk_q)
        ucm_pkg::BRK_IDLE:
          if (cmd[ucm_pkg::CMD_BRK_BEG]) brk_q <= ucm_pkg::BRK_WAIT;
        ucm_pkg::BRK_WAIT:
          if (!tx_busy) begin
            brk_q     <= ucm_pkg::BRK_SEND;
            brk_cnt_q <= 5'h00;
          end
        // stop on the end command once BRK_MIN_BITS bit periods have passed, then idle high for BRK_IDLE_BITS
        ucm_pkg::BRK_SEND: begin
          if (bit_tick && brk_cnt_q < ucm_pkg::BRK_MIN_BITS) brk_cnt_q <= brk_cnt_q + 5'h01;
          if (cmd[ucm_pkg::CMD_BRK_END] && brk_cnt_q >= ucm_pkg::BRK_MIN_BITS) begin
            brk_q     <= ucm_pkg::BRK_TRAIL;
            brk_cnt_q <= 5'h00;
          end
        end
        ucm_pkg::BRK_TRAIL:
          if (bit_tick) begin
            if (brk_cnt_q == ucm_pkg::BRK_IDLE_BITS - 5'h01) brk_q <= ucm_pkg::BRK_IDLE;
            else brk_cnt_q <= brk_cnt_q + 5'h01;
          end
        default: brk_q <= ucm_pkg::BRK_IDLE;
      endcase
    end
  end
  assign brk_line = brk_q == ucm_pkg::BRK_SEND;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    state_q = 32'h0000_0000;
    state_q[ucm_pkg::ST_RXRDY]   = f_rxrdy;
    state_q[ucm_pkg::ST_TXRDY]   = tx_active && !tx_busy;
    state_q[ucm_pkg::ST_BRK]     = f_brk;
    state_q[ucm_pkg::ST_OVR]     = f_ovr;
    state_q[ucm_pkg::ST_FRAME]   = f_frm;
    state_q[ucm_pkg::ST_PAR]     = f_par;
    state_q[ucm_pkg::ST_TIMEOUT] = to_flag;
    state_q[ucm_pkg::ST_TXEMPTY] = tx_active && !tx_busy && brk_q == ucm_pkg::BRK_IDLE;
    state_q[ucm_pkg::ST_ITER]    = f_itr | f_und;
    state_q[ucm_pkg::ST_NACK]    = f_nak;
    state_q[ucm_pkg::ST_MANCHESTER_ERROR_FLAG]  = f_man;
  end
  assign irq_mask_q = ucm_pkg::RST_ZERO;

  always_comb begin
    unique case (paddr)
      ucm_pkg::OFS_MODE:     prdata = mode_q;
      ucm_pkg::OFS_IRQ_MASK: prdata = irq_mask_q;
      ucm_pkg::OFS_STATE:    prdata = state_q;
      ucm_pkg::OFS_RXHOLD:   prdata = rxhold_q;
      ucm_pkg::OFS_BAUD:     prdata = baud_q;
      ucm_pkg::OFS_RXTO:     prdata = rxto_q;
      ucm_pkg::OFS_TXTG:     prdata = txtg_q;
      ucm_pkg::OFS_RATIO:    prdata = ratio_q;
      ucm_pkg::OFS_IRFILT:   prdata = irfilt_q;
      ucm_pkg::OFS_MANCH:    prdata = manch_q;
      ucm_pkg::OFS_WP_MODE:  prdata = {31'h00000000, wp_en_q};
      ucm_pkg::OFS_WP_STATE: prdata = {16'h0000, 4'h0, wp_src_q, 7'h00, wp_viol_q};
      default:               prdata = 32'h0000_0000;
    endcase
  end
endmodule
`default_nettype wire

// >>> ucm_ctrl_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ucm_ctrl_chk (
  input wire logic        pclk,         // clock
  input wire logic        presetn,      // reset, active low
  input wire logic        psel,         // apb select
  input wire logic        penable,      // apb enable
  input wire logic        pwrite,       // apb direction
  input wire logic [7:0]  paddr,        // apb address
  input wire logic [31:0] pwdata,       // apb write data
  input wire logic        rxd_pin,      // serial in pin
  input wire logic        txd_pin,      // serial out pin
  input wire logic        tx_serial,    // transmitter out
  input wire logic        rx_serial,    // receiver in
  input wire logic        rx_reset,     // receiver reset
  input wire logic        tx_reset,     // transmitter reset
  input wire logic        rx_active,    // receiver on
  input wire logic        tx_active,    // transmitter on
  input wire logic        term_ready_n, // terminal ready
  input wire logic        req_send_n    // request to send
);
  // ---------------------------------------
  // shadow of protection and channel field
  // ---------------------------------------
  logic       wp_q;
  logic [1:0] ch_q;
  // a break pulls the line low; normal and local routing checks stop once one is asked for
  logic       brk_q;
  wire        wr  = psel && penable && pwrite;
  wire        cmd = wr && paddr == ucm_pkg::OFS_CMD;
  wire        key = pwdata[31:8] == ucm_pkg::WP_KEY;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= 1'b0;
      ch_q <= 2'h0;
      brk_q <= 1'b0;
    end else begin
      if (cmd && pwdata[9]) brk_q <= 1'b1;
      if (wr && paddr == ucm_pkg::OFS_WP_MODE && key) wp_q <= pwdata[0];
      if (wr && paddr == ucm_pkg::OFS_MODE && !wp_q) ch_q <= pwdata[15:14];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_NORMAL: assert property (ch_q == 2'h0 && !brk_q |->
    txd_pin == tx_serial && rx_serial == rxd_pin)
    else $error("normal routing wrong");
  AST_ECHO: assert property (ch_q == 2'h1 |-> txd_pin == rxd_pin && rx_serial == rxd_pin)
    else $error("echo routing wrong");
  AST_LOCAL: assert property (ch_q == 2'h2 && !brk_q |-> txd_pin && rx_serial == tx_serial)
    else $error("local loopback routing wrong");
  AST_REMOTE: assert property (ch_q == 2'h3 |-> txd_pin == rxd_pin && !rx_active && !tx_active)
    else $error("remote loopback wrong");
  AST_RESETS: assert property (rx_reset == (cmd && pwdata[2]) && tx_reset == (cmd && pwdata[3]))
    else $error("reset pulse wrong");
  AST_RX_CMD: assert property (cmd && (pwdata[4] || pwdata[5]) && ch_q != 2'h3 |=> rx_active != $past(pwdata[5]))
    else $error("receiver enable wrong");
  AST_TX_OFF: assert property (cmd && pwdata[7] |=> !tx_active [*2])
    else $error("transmitter disable wrong");
  AST_TRDY: assert property (cmd && (pwdata[16] || pwdata[17]) |=> term_ready_n == !$past(pwdata[16]))
    else $error("terminal ready wrong");
  AST_RTS: assert property (cmd && (pwdata[18] || pwdata[19]) |=> req_send_n == !$past(pwdata[18]))
    else $error("request to send wrong");
  AST_PIN_HOLD: assert property (!cmd |=> $stable(term_ready_n) && $stable(req_send_n))
    else $error("modem pin moved without command");
endmodule
bind ucm_ctrl ucm_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .rxd_pin, .txd_pin, .tx_serial, .rx_serial, .rx_reset, .tx_reset, .rx_active, .tx_active,
  .term_ready_n, .req_send_n);
`default_nettype wire

// >>> ucm_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ucm_peer (
  input wire logic pclk,    // clock
  input wire logic presetn, // reset, active low
  input wire logic talk,    // frame in progress
  output logic     rxd      // line into block
);
  logic [7:0] lfsr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lfsr_q <= 8'h5a;
    else lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end
  // line idles high between frames, busy pattern inside
  assign rxd = talk ? lfsr_q[0] : 1'b1;
endmodule
`default_nettype wire

// >>> ucm_pkg.sv
package ucm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_MODE     = 8'h04;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h08;
  localparam logic [7:0] OFS_IRQ_DIS  = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_STATE    = 8'h14;
  localparam logic [7:0] OFS_RXHOLD   = 8'h18;
  localparam logic [7:0] OFS_TXHOLD   = 8'h1c;
  localparam logic [7:0] OFS_BAUD     = 8'h20;
  localparam logic [7:0] OFS_RXTO     = 8'h24;
  localparam logic [7:0] OFS_TXTG     = 8'h28;
  localparam logic [7:0] OFS_RATIO    = 8'h40;
  localparam logic [7:0] OFS_ERRCNT   = 8'h44;
  localparam logic [7:0] OFS_IRFILT   = 8'h4c;
  localparam logic [7:0] OFS_MANCH    = 8'h50;
  localparam logic [7:0] OFS_WP_MODE  = 8'he4;
  localparam logic [7:0] OFS_WP_STATE = 8'he8;

  // reset values
  localparam logic [31:0] RST_ZERO  = 32'h0000_0000;
  localparam logic [31:0] RST_RATIO = 32'h0000_0174;
  localparam logic [31:0] RST_MANCH = 32'h3001_1004;

  // command bit positions
  localparam int CMD_RX_RST   = 2;
  localparam int CMD_TX_RST   = 3;
  localparam int CMD_RX_ON    = 4;
  localparam int CMD_RX_OFF   = 5;
  localparam int CMD_TX_ON    = 6;
  localparam int CMD_TX_OFF   = 7;
  localparam int CMD_STA_CLR  = 8;
  localparam int CMD_BRK_BEG  = 9;
  localparam int CMD_BRK_END  = 10;
  localparam int CMD_TO_ARM   = 11;
  localparam int CMD_ADDR     = 12;
  localparam int CMD_ITER_CLR = 13;
  localparam int CMD_NACK_CLR = 14;
  localparam int CMD_TO_RST   = 15;
  localparam int CMD_TRDY_LO  = 16;
  localparam int CMD_TRDY_HI  = 17;
  localparam int CMD_RTS_LO   = 18;
  localparam int CMD_RTS_HI   = 19;

  // mode register fields
  localparam int MODE_OP_LSB = 0;
  localparam int MODE_PAR_LSB = 9;
  localparam int MODE_CH_LSB = 14;
  localparam logic [3:0] OP_SPI_MASTER = 4'he;
  localparam logic [3:0] OP_SPI_SLAVE  = 4'hf;
  localparam logic [3:0] OP_ISO_T0     = 4'h4;
  localparam logic [3:0] OP_ISO_T1     = 4'h6;
  localparam logic [2:0] PAR_MULTIDROP = 3'h6;

  typedef enum logic [1:0] {
    CH_NORMAL = 2'h0,
    CH_ECHO   = 2'h1,
    CH_LOCAL  = 2'h2,
    CH_REMOTE = 2'h3
  } ucm_chan_t;

  // channel status bit positions
  localparam int ST_RXRDY   = 0;
  localparam int ST_TXRDY   = 1;
  localparam int ST_BRK     = 2;
  localparam int ST_OVR     = 5;
  localparam int ST_FRAME   = 6;
  localparam int ST_PAR     = 7;
  localparam int ST_TIMEOUT = 8;
  localparam int ST_TXEMPTY = 9;
  localparam int ST_ITER    = 10;
  localparam int ST_NACK    = 13;
  localparam int ST_MANCHESTER_ERROR_FLAG  = 24;

  // protection
  localparam logic [23:0] WP_KEY = 24'h555341;
  localparam int WP_KEY_LSB = 8;
  localparam logic [3:0] SRC_MODE   = 4'h1;
  localparam logic [3:0] SRC_BAUD   = 4'h2;
  localparam logic [3:0] SRC_RXTO   = 4'h3;
  localparam logic [3:0] SRC_TXTG   = 4'h4;
  localparam logic [3:0] SRC_RATIO  = 4'h5;
  localparam logic [3:0] SRC_IRFILT = 4'h6;
  localparam logic [3:0] SRC_MANCH  = 4'h7;
  localparam int SRC_LSB = 8;

  // break timing in bit periods
  localparam logic [4:0] BRK_MIN_BITS  = 5'd10;
  localparam logic [4:0] BRK_IDLE_BITS = 5'd12;

  typedef enum logic [3:0] {
    BRK_IDLE  = 4'b0001,
    BRK_WAIT  = 4'b0010,
    BRK_SEND  = 4'b0100,
    BRK_TRAIL = 4'b1000
  } ucm_brk_t;
endpackage

// >>> usart_control_test_modes_test.sv
`timescale 1ns/1ps
`default_nettype none
module usart_control_test_modes_test;
  logic pclk, presetn, psel, penable, pwrite, bit_tick, tx_serial, rx_char_done, talk, tx_busy;
  logic pready, pslverr, rxd_pin, txd_pin, rx_serial, rx_reset, tx_reset, rx_active;
  logic tx_active, addr_mark, tx_hold_wr, term_ready_n, req_send_n;
  logic [7:0]  paddr, ev;
  logic [8:0]  tx_hold_data;
  logic [31:0] pwdata, prdata, keep [7];
  logic [63:0] q [$];
  logic [7:0]  ro [11] = '{8'h20, 8'h24, 8'h28, 8'h40, 8'h4c, 8'h50, 8'he4, 8'he8, 8'h10, 8'h18, 8'h30};
  logic [7:0]  pv [7] = '{8'h04, 8'h20, 8'h24, 8'h28, 8'h40, 8'h4c, 8'h50};
  logic [31:0] cw [5] = '{32'hc, 32'h50050, 32'h20030, 32'hc00d0, 32'h80080};
  logic [3:0]  ce [5] = '{4'b0001, 4'b1100, 4'b0110, 4'b1010, 4'b1011};
  int errors, checked;
  ucm_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .bit_tick, .rxd_pin, .txd_pin, .tx_serial, .rx_serial, .tx_busy,
    .rx_char_done, .rx_char(9'h0), .ev_parity(ev[0]), .ev_frame(ev[1]), .ev_overrun(ev[2]),
    .ev_manchester_error_flag(ev[3]), .ev_underrun(ev[4]), .ev_break(ev[5]), .ev_iter(ev[6]), .ev_nack(ev[7]),
    .rx_reset, .tx_reset, .rx_active, .tx_active, .addr_mark, .tx_hold_wr, .tx_hold_data,
    .term_ready_n, .req_send_n);
  ucm_peer u_peer (.pclk(pclk), .presetn(presetn), .talk(talk), .rxd(rxd_pin));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    complete_run();
  end
  task automatic complete_run();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // called just after a rising edge, returns one edge after release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    q.push_back({m, exp});
    apb(1'b0, a, 32'h0);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0) begin
      check(prdata & q[0][63:32], q[0][31:0] & q[0][63:32]);
      void'(q.pop_front());
    end
    if (tx_hold_wr === 1'b1) check({23'h0, tx_hold_data}, pwdata & 32'h1ff);
  end
  // -----------------
  // main sequence
  // -----------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
    pwdata = 32'h0; bit_tick = 1'b0; tx_serial = 1'b1; rx_char_done = 1'b0; ev = 8'h0;
    talk = 1'b0; errors = 0; checked = 0; tx_busy = 1'b0;
    void'($urandom(76570));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 11; i++) rd(ro[i], ro[i] == 8'h40 ? ucm_pkg::RST_RATIO :
      ro[i] == 8'h50 ? ucm_pkg::RST_MANCH : 32'h0, 32'hffffffff);
    $display("reset values done");
    for (int i = 0; i < 7; i++) begin
      keep[i] = $urandom & 32'h3;
      apb(1'b1, pv[i], keep[i]);
    end
    apb(1'b1, ucm_pkg::OFS_WP_MODE, {ucm_pkg::WP_KEY, 8'h1});
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, pv[i], ~keep[i]);
      rd(pv[i], keep[i], 32'h3);
      rd(ucm_pkg::OFS_WP_STATE, {20'h0, 4'(i + 1), 8'h1}, 32'hf01);
    end
    apb(1'b1, ucm_pkg::OFS_CMD, 32'h10000);
    check({31'h0, term_ready_n}, 32'h0);
    apb(1'b1, ucm_pkg::OFS_WP_MODE, 32'h0);
    rd(ucm_pkg::OFS_WP_STATE, 32'h1, 32'h1);
    apb(1'b1, ucm_pkg::OFS_WP_MODE, {ucm_pkg::WP_KEY, 8'h0});
    rd(ucm_pkg::OFS_WP_STATE, 32'h0, 32'h1);
    apb(1'b1, ucm_pkg::OFS_BAUD, 32'h3);
    rd(ucm_pkg::OFS_BAUD, 32'h3, 32'h3);
    $display("protection done");
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, ucm_pkg::OFS_MODE, 32'(c) << 14);
      talk <= 1'b1;
      repeat (6) begin
        @(posedge pclk);
        tx_serial <= 1'($urandom);
        @(negedge pclk);
        check({31'h0, txd_pin}, {31'h0, c == 0 ? tx_serial : c == 2 ? 1'b1 : rxd_pin});
        if (c != 3) check({31'h0, rx_serial}, {31'h0, c == 2 ? tx_serial : rxd_pin});
      end
      @(posedge pclk);
    end
    talk <= 1'b0;
    apb(1'b1, ucm_pkg::OFS_TXHOLD, $urandom & 32'h1ff);
    apb(1'b1, ucm_pkg::OFS_MODE, 32'h0);
    $display("channel modes done");
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ucm_pkg::OFS_CMD, cw[i] | ($urandom & 32'hfff00003));
      @(negedge pclk);
      check({28'h0, rx_active, tx_active, term_ready_n, req_send_n}, {28'h0, ce[i]});
      @(posedge pclk);
    end
    $display("commands done");
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, ucm_pkg::OFS_MODE, 32'(m) * 32'hc00);
      apb(1'b1, ucm_pkg::OFS_CMD, 32'h1000);
      check({31'h0, addr_mark}, 32'(m));
    end
    apb(1'b1, ucm_pkg::OFS_TXHOLD, $urandom & 32'h1ff);
    check({31'h0, addr_mark}, 32'h0);
    $display("address mark done");
    ev <= 8'hbf;
    @(posedge pclk);
    ev <= 8'h0;
    rd(ucm_pkg::OFS_STATE, 32'h010024e4, 32'h010024e4);
    apb(1'b1, ucm_pkg::OFS_CMD, 32'h4100);
    rd(ucm_pkg::OFS_STATE, 32'h0, 32'h010024e4);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, ucm_pkg::OFS_MODE, 32'(m) * 32'h4);
      ev <= 8'h40;
      @(posedge pclk);
      ev <= 8'h0;
      apb(1'b1, ucm_pkg::OFS_CMD, 32'h2000);
      rd(ucm_pkg::OFS_STATE, m == 0 ? 32'h400 : 32'h0, 32'h400);
    end
    apb(1'b1, ucm_pkg::OFS_RXTO, 32'h1);
    bit_tick <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, ucm_pkg::OFS_MODE, k == 0 ? 32'h0 : 32'he);
      apb(1'b1, ucm_pkg::OFS_CMD, 32'h800);
      rx_char_done <= 1'b1;
      @(posedge pclk);
      rx_char_done <= 1'b0;
      repeat (20) @(posedge pclk);
      rd(ucm_pkg::OFS_STATE, k == 0 ? 32'h100 : 32'h0, 32'h100);
    end
    $display("status and timeout done");
    tx_serial <= 1'b1;
    tx_busy <= 1'b1;
    apb(1'b1, ucm_pkg::OFS_CMD, 32'h200);
    check({31'h0, txd_pin}, 32'h1);
    tx_busy <= 1'b0;
    repeat (3) @(posedge pclk);
    check({31'h0, txd_pin}, 32'h0);
    apb(1'b1, ucm_pkg::OFS_CMD, 32'h400);
    check({31'h0, txd_pin}, 32'h0);
    repeat (12) @(posedge pclk);
    apb(1'b1, ucm_pkg::OFS_CMD, 32'h400);
    check({31'h0, txd_pin}, 32'h1);
    $display("break done");
    complete_run();
  end
endmodule
`default_nettype wire
